// File: verilog/dfg_defines.svh
// Constants for the DDR input FIFO and gearing block.
// Assumes inclusion by bare name from design files.
`ifndef DFG_DEFINES_SVH
`define DFG_DEFINES_SVH
`define DFG_PTR_W        3
`define DFG_FIFO_DEPTH   8
`define DFG_PTR_OFFSET   3'h4
`define DFG_GEAR_X1      2'h0
`define DFG_GEAR_X2      2'h1
`define DFG_GEAR_71      2'h2
`define DFG_WORD_W       7
`define DFG_GEAR_SPARE   2'h3
`define DFG_W_X1         4'h2
`define DFG_W_X2         4'h4
`define DFG_W_71         4'h7
`endif

// File: verilog/dfg_pkg.sv
// Types shared by the DDR input FIFO and gearing block.
// Assumes the defines header is on the include path.
`include "dfg_defines.svh"
package dfg_pkg;
    typedef logic [`DFG_PTR_W-1:0] dfg_ptr_t;
    typedef struct packed {
        dfg_ptr_t wr;
        dfg_ptr_t rd;
    } dfg_ptrs_t;
    typedef struct packed {
        logic [`DFG_WORD_W-1:0] data;
        logic                   valid;
    } dfg_word_t;
endpackage

// File: verilog/dfg_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; used as the slow-word output buffer.
`timescale 1ns/1ps
module dfg_fifo
    import dfg_pkg::*;
#(
    parameter int WIDTH = 7,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dfg_fst_t;
    dfg_fst_t st;
    dfg_fst_t next_st;
    logic     push;
    logic     pop;

    // Honest flags from the occupancy count
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: verilog/dfg_top.sv
// DDR read capture: per-pin input FIFO, shared pointer control, gearing.
// Assumes strobe, edge and slow clocks arrive as pins sampled by core_clk.
// Assumes gear_mode only changes while gear_reset is held.
// Assumes the core drains each output buffer before it fills.
// Overview of operation
// RULE1 - One input FIFO per single-ended data pin.
// RULE2 - FIFO output feeds the deserialising gear logic.
// RULE3 - FIFO moves data from strobe domain to edge clock domain.
// RULE4 - FIFO writes on edges of the delayed strobe.
// RULE5 - FIFO reads on edges of the edge clock.
// RULE6 - Edge clock must run at the strobe frequency.
// RULE7 - One FIFO control block per strobe group.
// RULE8 - Control block broadcasts shared pointers to every cell pair.
// RULE9 - Each pin gives one high-speed serial bit.
// RULE10 - Parallel word is 2, 4 or 7 bits per gearing ratio.
// RULE11 - Core word align request slips the word boundary.
// RULE12 - Reset input clears gear and capture registers.
// RULE13 - Read data is captured on the group strobe clock.
// RULE14 - Control block drives separate 3-bit read and write pointers.
// RULE15 - Read pointer trails write pointer by a fixed offset.
`timescale 1ns/1ps
module dfg_top
    import dfg_pkg::*;
#(
    parameter int PINS  = 4,
    parameter int DEPTH = `DFG_FIFO_DEPTH,
    parameter int OBUF  = 8
) (
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    input  wire logic                          strobe_clock,
    input  wire logic                          edge_clock,
    input  wire logic                          slow_clock,
    input  wire logic [PINS-1:0]               serial_in,
    input  wire logic                          gear_reset,
    input  wire logic [1:0]                    gear_mode,
    input  wire logic                          word_align_request,
    output dfg_ptrs_t                          group_pointers,
    output logic [PINS-1:0]                    word_valid,
    input  wire logic [PINS-1:0]               word_ready,
    output logic [PINS-1:0][`DFG_WORD_W-1:0]   word_data
);
    // Read-side phases, one-hot so each phase is a single flop
    typedef enum logic [2:0] {
        dfg_rd_idle = 3'b001,
        dfg_rd_fill = 3'b010,
        dfg_rd_run  = 3'b100
    } dfg_rd_state_t;

    typedef struct packed {
        // Two-flop synchronisers for the strobe, edge, slow, gear reset, align and data pins
        logic [1:0]                       s_sync;
        logic [1:0]                       e_sync;
        logic [1:0]                       k_sync;
        logic [1:0]                       r_sync;
        logic [1:0]                       a_sync;
        logic [PINS-1:0][1:0]             d_sync;

        // Previous synchronised levels for edge detection
        logic                             s_last;
        logic                             e_last;
        logic                             k_last;
        logic                             a_last;

        // Group control shared by all pins of the strobe group
        dfg_rd_state_t                    rd_state;
        dfg_ptr_t                         wr;
        dfg_ptr_t                         rd;

        // Per-pin capture FIFO and gear shifter; bit count and slip are shared by all pins
        logic [PINS-1:0][DEPTH-1:0]       fifo;
        logic [PINS-1:0][13:0]            shreg;
        logic [3:0]                       bitcnt;
        logic [2:0]                       slip;

        // Finished word waiting for a slow clock edge
        logic [PINS-1:0][`DFG_WORD_W-1:0] held;
        logic                             held_new;
        logic [PINS-1:0][`DFG_WORD_W-1:0] outw;
        logic [PINS-1:0]                  outv;
    } dfg_st_t;

    // Reset value; the read phase must start in its idle code, since
    // an all-zero state would be an illegal one-hot code
    localparam dfg_st_t st_reset_value =
        '{rd_state: dfg_rd_idle, default: '0};

    dfg_st_t st;
    dfg_st_t next_st;
    logic    s_rise;
    logic    e_rise;
    logic    k_rise;
    logic    a_rise;
    logic    grst;
    logic    rd_go;
    logic    word_done;
    logic [3:0] width;
    logic [PINS-1:0] buf_ready;

    // Edge detect on the second sync stage only
    assign s_rise = st.s_sync[1] && !st.s_last;
    assign e_rise = st.e_sync[1] && !st.e_last;
    assign k_rise = st.k_sync[1] && !st.k_last;
    assign a_rise = st.a_sync[1] && !st.a_last;
    assign grst   = st.r_sync[1];

    // Word width per gearing ratio [RULE10]
    always_comb begin
        unique case (gear_mode)
            `DFG_GEAR_X1:    width = `DFG_W_X1;
            `DFG_GEAR_X2:    width = `DFG_W_X2;
            `DFG_GEAR_71:    width = `DFG_W_71;
            `DFG_GEAR_SPARE: width = `DFG_W_71;  // Spare code runs as 7:1
        endcase
    end

    // One pointer pair fans out to every cell pair [RULE8] [RULE14]
    assign group_pointers = '{wr: st.wr, rd: st.rd};

    // A read slot: edge clock rise once the lead is built [RULE5]
    assign rd_go     = e_rise && (st.rd_state == dfg_rd_run);
    // Last bit of a word falls in this read slot [RULE10]
    assign word_done = rd_go && (st.bitcnt + 4'h1 >= width);

    always_comb begin
        next_st = st;
        // Two-stage synchronisers for the strobe, edge, slow, gear reset, align and data pins
        next_st.s_sync = {st.s_sync[0], strobe_clock};
        next_st.e_sync = {st.e_sync[0], edge_clock};
        next_st.k_sync = {st.k_sync[0], slow_clock};
        next_st.r_sync = {st.r_sync[0], gear_reset};
        next_st.a_sync = {st.a_sync[0], word_align_request};
        for (int p = 0; p < PINS; p++) begin
            next_st.d_sync[p] = {st.d_sync[p][0], serial_in[p]};  // [RULE9]
        end
        next_st.s_last = st.s_sync[1];
        next_st.e_last = st.e_sync[1];
        next_st.k_last = st.k_sync[1];
        next_st.a_last = st.a_sync[1];

        // Group control: one write pointer per strobe group [RULE7]
        if (s_rise) begin
            for (int p = 0; p < PINS; p++) begin
                // Capture on strobe edge into per-pin FIFO [RULE1] [RULE4]
                next_st.fifo[p][st.wr] = st.d_sync[p][1];  // [RULE13]
            end
            next_st.wr = st.wr + 1'b1;
        end

        // Read phase: wait out gear reset, build the lead, then run.
        // Equal clock rates keep the lead fixed, so no flags are kept.
        unique case (st.rd_state)
            dfg_rd_idle: begin
                next_st.rd_state = dfg_rd_fill;
            end
            dfg_rd_fill: begin
                // Reads start once a fixed lead is built [RULE15]
                if (s_rise && st.wr == `DFG_PTR_OFFSET - 3'h1) begin
                    next_st.rd_state = dfg_rd_run;
                end
            end
            dfg_rd_run: begin
                next_st.rd_state = dfg_rd_run;
            end
            default: begin
                // Upset flop: rebuild the lead rather than read blind
                next_st.rd_state = dfg_rd_idle;
            end
        endcase

        // Slow clock edge hands the word to the output buffer. This
        // runs before the read slot, so a word finished in the same
        // cycle sets the pending flag again and waits for the next edge.
        next_st.outv = '0;
        if (k_rise && st.held_new) begin
            next_st.held_new = 1'b0;
            for (int p = 0; p < PINS; p++) begin
                next_st.outw[p] = st.held[p];
                next_st.outv[p] = buf_ready[p];  // Full buffer drops word
            end
        end

        // Read on edge clock; same rate keeps the lead constant [RULE5]
        if (rd_go) begin
            next_st.rd = st.rd + 1'b1;
            for (int p = 0; p < PINS; p++) begin
                // FIFO output into the gear shifter [RULE2] [RULE3]
                next_st.shreg[p] = {st.shreg[p][12:0], st.fifo[p][st.rd]};
            end
            if (word_done) begin
                next_st.bitcnt = 4'h0;
                for (int p = 0; p < PINS; p++) begin
                    next_st.held[p] = '0;
                    for (int b = 0; b < `DFG_WORD_W; b++) begin
                        if (4'(b) < width) begin
                            next_st.held[p][b] =
                                next_st.shreg[p][4'(b) + 4'(st.slip)];
                        end
                    end
                end
                next_st.held_new = 1'b1;
            end else begin
                next_st.bitcnt = st.bitcnt + 4'h1;
            end
        end

        // Align request slips the boundary by one bit [RULE11]
        if (a_rise) begin
            next_st.slip = (4'(st.slip) + 4'h1 >= width) ? 3'h0
                                                       : st.slip + 3'h1;
        end

        // Gear reset clears capture and gear state [RULE12]
        if (grst) begin
            next_st.wr       = '0;
            next_st.rd       = '0;
            next_st.rd_state = dfg_rd_idle;
            next_st.shreg    = '0;
            next_st.bitcnt   = 4'h0;
            next_st.slip     = 3'h0;
            next_st.held     = '0;
            next_st.held_new = 1'b0;
            next_st.outv     = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= st_reset_value;
        end else begin
            st <= next_st;
        end
    end

    // Per-pin output buffer; the core may stall it with word_ready
    for (genvar p = 0; p < PINS; p++) begin : g_buf
        dfg_fifo #(
            .WIDTH (`DFG_WORD_W),
            .DEPTH (OBUF)
        ) u_buf (
            .clk       (core_clk),
            .rstn      (rstn),
            .in_valid  (st.outv[p]),
            .in_ready  (buf_ready[p]),
            .in_data   (st.outw[p]),
            .out_valid (word_valid[p]),
            .out_ready (word_ready[p]),
            .out_data  (word_data[p])
        );
    end
endmodule

// File: verif/dfg_top_sva.sv
// Port checks for the DDR input FIFO and gearing top.
// Assumes one core_clk domain; bound at the foot of this file.
`timescale 1ns/1ps
`include "dfg_defines.svh"
module dfg_top_sva
    import dfg_pkg::*;
#(
    parameter int PINS = 4
) (
    input wire logic                       core_clk,
    input wire logic                       rstn,
    input wire logic                       strobe_clock,
    input wire logic                       edge_clock,
    input wire logic [1:0]                 gear_mode,
    input wire logic [PINS-1:0]            word_ready,
    input wire dfg_ptrs_t                  group_pointers,
    input wire logic [PINS-1:0]            word_valid,
    input wire logic [PINS-1:0][`DFG_WORD_W-1:0] word_data
);
    wire dfg_ptr_t wr = group_pointers.wr;
    wire dfg_ptr_t rd = group_pointers.rd;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Pointers step once per pin rise; a gear reset may clear them
    wr_step_a: assert property ($changed(wr)
        |-> wr == $past(wr) + 3'h1 || wr == 3'h0)
        else $error("write pointer jumped");
    rd_step_a: assert property ($changed(rd)
        |-> rd == $past(rd) + 3'h1 || rd == 3'h0)
        else $error("read pointer jumped");
    wr_strobe_a: assert property ($changed(wr) && wr != 3'h0
        |-> $past(strobe_clock, 2)) else $error("write without strobe");
    rd_edge_a: assert property ($changed(rd) && rd != 3'h0
        |-> $past(edge_clock, 2)) else $error("read without edge");
    wr_once_a: assert property ($changed(wr) && wr != 3'h0
        |=> (wr == 3'h0 || $stable(wr)) [*3]) else $error("double write");
    ptr_lead_a: assert property ($changed(rd) && rd != 3'h0
        |-> 3'(wr - rd) inside {[3'h3:3'h5]}) else $error("lead lost");
    // Narrow modes leave the unused upper bits clear
    word_width_a: assert property (word_valid[0] && !gear_mode[1]
        |-> word_data[0][6:4] == 3'h0
        && (gear_mode[0] || word_data[0][3:2] == 2'h0))
        else $error("bits above width set");
    word_hold_a: assert property (word_valid[0] && !word_ready[0]
        |=> word_valid[0] && $stable(word_data[0])) else $error("word lost");
    group_a: assert property (word_valid[0] |-> &word_valid)
        else $error("pins out of step");
endmodule
bind dfg_top dfg_top_sva #(.PINS(PINS)) i_sva (.core_clk(core_clk),
    .rstn(rstn), .strobe_clock(strobe_clock), .edge_clock(edge_clock),
    .gear_mode(gear_mode), .word_ready(word_ready),
    .group_pointers(group_pointers), .word_valid(word_valid),
    .word_data(word_data));

// File: verif/dfg_mem_model.sv
// Memory side: delayed read strobe and one serial bit per data pin.
// Assumes the bench sets the word width and the repeating pattern.
`timescale 1ns/1ps
module dfg_mem_model #(
    parameter int PINS = 4
) (
    output logic            strobe_clock,
    output logic [PINS-1:0] serial_in,
    input  wire logic [2:0] width,
    input  wire logic [6:0] pattern
);
    int idx = 0;
    // Data launches on the fall so it is centred on the capturing rise;
    // pin k runs k bits ahead, so its words are rotations of pin 0
    initial begin
        strobe_clock = 1'b0;
        serial_in = '0;
        #61;
        forever begin
            #100 strobe_clock = 1'b1;
            #100 strobe_clock = 1'b0;
            idx++;
            for (int k = 0; k < PINS; k++)
                serial_in[k] = pattern[width - 1 - (idx + k) % width];
        end
    end
endmodule

// File: verif/test_ddr_input_fifo_gearing.sv
// Self-checking bench for the DDR input FIFO and gearing block.
// Assumes the memory model makes strobe and data; bench makes the rest.
`timescale 1ns/1ps
`include "dfg_defines.svh"
module test_ddr_input_fifo_gearing;
    import dfg_pkg::*;
    logic            core_clk = 1'b0;
    logic            rstn = 1'b0;
    logic            edge_clock = 1'b0;
    logic            slow_clock = 1'b0;
    logic            gear_reset = 1'b1;
    logic [1:0]      gear_mode = `DFG_GEAR_X1;
    logic            word_align_request = 1'b0;
    logic [3:0]      word_ready = 4'h0;
    logic [2:0]      width = 3'h2;
    logic [6:0]      pattern = 7'h02;
    logic            strobe_clock;
    logic [3:0]      serial_in;
    dfg_ptrs_t       group_pointers;
    logic [3:0]      word_valid;
    logic [3:0][6:0] word_data;
    logic [6:0]      w0;
    int              fails = 0;
    int              tests_run = 0;
    dfg_top #(.PINS(4)) i_dut (.core_clk(core_clk), .rstn(rstn),
        .strobe_clock(strobe_clock), .edge_clock(edge_clock),
        .slow_clock(slow_clock), .serial_in(serial_in),
        .gear_reset(gear_reset), .gear_mode(gear_mode),
        .word_align_request(word_align_request),
        .group_pointers(group_pointers), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    dfg_mem_model #(.PINS(4)) i_mem (.strobe_clock(strobe_clock),
        .serial_in(serial_in), .width(width), .pattern(pattern));
    // Clocks; edge clock matches the strobe rate, phase offset on purpose
    always #12.5 core_clk = ~core_clk;
    initial begin
        #7;
        forever #100 edge_clock = ~edge_clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [6:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [6:0] rotl(input logic [6:0] x, input int k);
        logic [6:0] r;
        r = x;
        repeat (k) r = ((r << 1) | (r >> (width - 1))) & ~(7'h7F << width);
        return r;
    endfunction
    // Twelve slow ticks against eight places, then stop and drain
    task automatic fill_drain(output logic [6:0] word);
        word_ready = 4'h0;
        repeat (24) begin
            tick(4 * width);
            slow_clock = ~slow_clock;
        end
        tick(8);
        word = word_data[0];
        for (int n = 0; n < 9; n++) begin
            check("valid", n < 8 ? 7'h0F : 7'h00, 7'(word_valid));
            for (int k = 0; k < 4 && n < 8; k++)
                check("data", rotl(word, k), word_data[k]);
            word_ready = 4'hF;
            tick(1);
            word_ready = 4'h0;
            tick(1);
        end
    endtask
    // Mode change under gear reset; word must be a rotation of the pattern
    task automatic gear_run(input logic [1:0] m, input logic [2:0] w,
                            input logic [6:0] p);
        logic hit;
        gear_reset = 1'b1;
        gear_mode = m;
        width = w;
        pattern = p;
        tick(8);
        check("pointers", 7'h00, 7'(group_pointers));
        gear_reset = 1'b0;
        tick(200);
        fill_drain(w0);
        hit = 1'b0;
        for (int r = 0; r < 7; r++)
            hit = hit | (rotl(p, r) === w0);
        check("phase", 7'h01, 7'(hit));
    endtask
    // One align rise moves the boundary by exactly one bit
    task automatic align_slip;
        logic [6:0] prev;
        prev = w0;
        word_align_request = 1'b1;
        tick(8);
        word_align_request = 1'b0;
        tick(200);
        fill_drain(w0);
        // One slip takes a window one bit older: a right rotation
        check("slip", rotl(prev, 6), w0);
    endtask
    task automatic test_done;
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tick(2);
        rstn = 1'b1;
        gear_run(`DFG_GEAR_X1, 3'h2, 7'h02);
        gear_run(`DFG_GEAR_X2, 3'h4, 7'h08);
        gear_run(`DFG_GEAR_71, 3'h7, 7'h59);
        gear_run(2'h3, 3'h7, 7'h59);
        align_slip();
        test_done();
    end
    // Watchdog well beyond the few thousand cycles the run needs
    initial begin
        #500000;
        fails++;
        test_done();
    end
endmodule
